// ---- design/bbd_pkg.sv ----
// Shared constants and types for the branch, bit and control decoder
package bbd_pkg;

	// ==========================================================
	// Widths
	localparam int PC_W = 12;
	localparam int BYTE_W = 8;

	// ==========================================================
	// Opcode fields
	localparam logic [2:0] LO_SBR_MASK = 3'h1;
	localparam logic [2:0] LO_CALL_JP = 3'h1;
	localparam logic [3:0] LO_BIT_TEST = 4'h3;
	localparam logic [3:0] LO_BIT_OP = 4'hb;
	localparam logic [3:0] LO_INDEX = 4'h5;
	localparam logic [3:0] LO_ACC = 4'h7;
	localparam logic [3:0] LO_CTRL = 4'hd;
	localparam logic [1:0] CND_ZERO_CLEAR = 2'h0;
	localparam logic [1:0] CND_CARRY_CLEAR = 2'h1;
	localparam logic [1:0] CND_ZERO_SET = 2'h2;
	localparam logic [1:0] CND_CARRY_SET = 2'h3;

	// ==========================================================
	// Control opcodes
	localparam logic [7:0] OP_IRQ_EXIT = 8'h4d;
	localparam logic [7:0] OP_SUBROUTINE_EXIT = 8'hcd;
	localparam logic [7:0] OP_STOP = 8'h6d;
	localparam logic [7:0] OP_WAIT = 8'hed;
	localparam logic [7:0] OP_NOP = 8'had;

	// ==========================================================
	// Displacement bias after the program counter has passed the instruction
	localparam logic [11:0] SHORT_BIAS = 12'h001;
	localparam logic [11:0] LONG_BIAS = 12'h002;
	localparam logic [11:0] PC_STEP = 12'h001;
	localparam logic [11:0] PC_RESET = 12'h000;

	// ==========================================================
	// Instruction kinds
	typedef enum logic [3:0] {
		K_SHORT_BRANCH,
		K_CALL,
		K_LONG_JUMP,
		K_BIT_TEST,
		K_BIT_OP,
		K_NOP,
		K_SUB_EXIT,
		K_IRQ_EXIT,
		K_STOP,
		K_WAIT,
		K_OTHER,
		K_ILLEGAL
	} bbd_kind_t;

	// Operations handed to the load/arithmetic unit
	typedef enum logic [3:0] {
		O_INC_X,
		O_LD_A_X,
		O_INC_Y,
		O_LD_A_Y,
		O_DATA_MOVE_IND,
		O_LOAD_IMMEDIATE,
		O_COMPARE_ACC_IND,
		O_COMPARE_IMMEDIATE,
		O_SUM_IND,
		O_SUM_IMMEDIATE,
		O_INC_IND,
		O_STORE_IND,
		O_MISC
	} bbd_other_t;

	typedef enum logic [2:0] {
		S_FETCH,
		S_OPER1,
		S_DSREAD,
		S_OPER2,
		S_EXEC,
		S_PAD,
		S_HANDOFF
	} bbd_state_t;

endpackage : bbd_pkg

// ---- design/bbd_bit_unit.sv ----
// Single-bit test and modify of a data-space byte
`timescale 1ns/1ns
module bbd_bit_unit
	import bbd_pkg::*;
(
	input wire logic [7:0] byte_i, // Byte read from data space
	input wire logic [2:0] pos_i, // Bit position
	input wire logic set_i, // 1 sets, 0 clears
	output logic [7:0] byte_o, // Byte with one bit changed
	output logic bit_o // Value of the selected bit
);

	// ==========================================================
	// Per-bit modify
	genvar gi;
	generate
		for (gi = 0; gi < BYTE_W; gi++)
		begin : g_bit
			assign byte_o[gi] = (pos_i == 3'(gi)) ? set_i : byte_i[gi];
		end
	endgenerate

	assign bit_o = byte_i[pos_i];

endmodule : bbd_bit_unit

// ---- design/bbd_decoder.sv ----
// Branch, bit manipulation, control and long jump/call sequencer
`timescale 1ns/1ns

// How it works
// - Conditional branch taken only when its flag or tested bit condition holds
// - Short branches 1 byte 2 cycles no flags; bit tests 3 bytes 5 cycles
// - Short branch adds 5-bit signed displacement, reach -15 to +16
// - Bit-test branch adds third-byte 8-bit displacement, reach -126 to +129
// - Bit-test branch copies tested bit into carry whether taken or not
// - Bit set/clear change any bit of any data byte, position from opcode
// - Bit set/clear take 2 bytes, 4 cycles, flags untouched
// - Control instructions 1 byte 2 cycles; only interrupt exit restores flags
// - With watchdog selected, stop performs wait instead
// - Long jump and call carry a 12-bit absolute target
// - Long jump and call take 2 bytes, 4 cycles, flags untouched
// - Even low nibbles 0 to e short branches; 1 is call, any high nibble
// - Low nibble 3: high bit0 picks clear/set test, bits 3:1 reversed give position
// - Low nibble 5: odd highs 1 to 7 index inc/load, even highs and highs 9 to f illegal
// - Low nibble 7: highs 0 to 8 map to accumulator operations, 7 illegal
// - Bit-direct position in opcode, target address in following byte
module bbd_decoder
	import bbd_pkg::*;
(
	input wire logic core_clk_i, // Core instruction clock
	input wire logic rst_i, // Asynchronous reset, active high
	output logic [11:0] pm_addr_o, // Program memory address
	output logic pm_rd_o, // Program memory read strobe
	input wire logic [7:0] pm_data_i, // Byte at pm_addr_o, same cycle
	output logic [7:0] ds_addr_o, // Data space address
	output logic ds_rd_o, // Data space read strobe
	input wire logic [7:0] ds_rdata_i, // Byte at ds_addr_o, same cycle
	output logic ds_wr_o, // Data space write strobe
	output logic [7:0] ds_wdata_o, // Data space write byte
	input wire logic z_flag_i, // Zero flag
	input wire logic c_flag_i, // Carry flag
	output logic c_wr_o, // Carry load pulse
	output logic c_val_o, // Carry value to load
	output logic flag_restore_o, // Restore saved flags pulse
	output logic stack_push_o, // Push return address pulse
	output logic [11:0] stack_push_data_o, // Return address
	output logic stack_pop_o, // Pop pulse
	input wire logic [11:0] stack_pop_data_i, // Top of stack
	input wire logic watchdog_sel_i, // Watchdog function selected
	output logic stop_req_o, // Stop mode request pulse
	output logic wait_req_o, // Wait mode request pulse
	output logic illegal_o, // Illegal opcode pulse
	output logic other_op_o, // Hand off to load/arithmetic unit
	output logic [3:0] other_class_o, // Handed-off operation
	output logic [7:0] other_opcode_o, // Handed-off opcode
	input wire logic other_done_i // Load/arithmetic unit finished
);

	// ==========================================================
	// Decode
	function automatic bbd_kind_t kind_of(input logic [7:0] op);
		bbd_kind_t k;
		k = K_OTHER;
		if ((op[2:0] & LO_SBR_MASK) == 3'h0)
		begin
			k = K_SHORT_BRANCH;
		end
		if ((op[2:0] & 3'h7) == LO_CALL_JP)
		begin
			k = op[3] ? K_LONG_JUMP : K_CALL;
		end
		if (op[3:0] == LO_BIT_TEST)
		begin
			k = K_BIT_TEST;
		end
		if (op[3:0] == LO_BIT_OP)
		begin
			k = K_BIT_OP;
		end
		if (op[3:0] == LO_INDEX && op[4] == 1'b0)
		begin
			k = K_ILLEGAL;
		end
		if (op[3:0] == LO_INDEX && op[7:4] > 4'h7)
		begin
			k = K_ILLEGAL;
		end
		if (op[3:0] == LO_ACC && op[7:4] == 4'h7)
		begin
			k = K_ILLEGAL;
		end
		case (op)
			OP_IRQ_EXIT: k = K_IRQ_EXIT;
			OP_SUBROUTINE_EXIT: k = K_SUB_EXIT;
			OP_STOP: k = K_STOP;
			OP_WAIT: k = K_WAIT;
			OP_NOP: k = K_NOP;
			default: ;
		endcase
		return k;
	endfunction : kind_of

	function automatic bbd_other_t other_of(input logic [7:0] op);
		bbd_other_t o;
		o = O_MISC;
		if (op[3:0] == LO_INDEX)
		begin
			case (op[7:4])
				4'h1: o = O_INC_X;
				4'h3: o = O_LD_A_X;
				4'h5: o = O_INC_Y;
				4'h7: o = O_LD_A_Y;
				default: o = O_MISC;
			endcase
		end
		if (op[3:0] == LO_ACC)
		begin
			case (op[7:4])
				4'h0: o = O_DATA_MOVE_IND;
				4'h1: o = O_LOAD_IMMEDIATE;
				4'h2: o = O_COMPARE_ACC_IND;
				4'h3: o = O_COMPARE_IMMEDIATE;
				4'h4: o = O_SUM_IND;
				4'h5: o = O_SUM_IMMEDIATE;
				4'h6: o = O_INC_IND;
				4'h8: o = O_STORE_IND;
				default: o = O_MISC;
			endcase
		end
		return o;
	endfunction : other_of

	// ==========================================================
	// State
	bbd_state_t state_q, state_d;
	bbd_kind_t kind_q, kind_d;
	logic [11:0] pc_q, pc_d;
	logic [7:0] op_q, op_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic bit_q, bit_d;
	logic [7:0] mod_byte;
	logic tested_bit;
	logic [2:0] bit_pos;
	logic short_take;
	logic [4:0] short_disp;

	assign bit_pos = {op_q[5], op_q[6], op_q[7]};
	assign short_disp = {op_q[7:4], op_q[3]};

	bbd_bit_unit u_bit (
		.byte_i(ds_rdata_i),
		.pos_i(bit_pos),
		.set_i(op_q[4]),
		.byte_o(mod_byte),
		.bit_o(tested_bit)
	);

	always_comb
	begin
		case (op_q[2:1])
			CND_ZERO_CLEAR: short_take = !z_flag_i;
			CND_CARRY_CLEAR: short_take = !c_flag_i;
			CND_ZERO_SET: short_take = z_flag_i;
			CND_CARRY_SET: short_take = c_flag_i;
			default: short_take = 1'b0;
		endcase
	end

	// ==========================================================
	// Sequencer
	always_comb
	begin
		state_d = state_q;
		kind_d = kind_q;
		pc_d = pc_q;
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		bit_d = bit_q;
		case (state_q)
			S_FETCH:
			begin
				op_d = pm_data_i;
				kind_d = kind_of(pm_data_i);
				pc_d = pc_q + PC_STEP;
				case (kind_of(pm_data_i))
					K_CALL, K_LONG_JUMP, K_BIT_TEST, K_BIT_OP: state_d = S_OPER1;
					K_OTHER: state_d = S_HANDOFF;
					default: state_d = S_EXEC;
				endcase
			end
			S_OPER1:
			begin
				addr_d = pm_data_i;
				pc_d = pc_q + PC_STEP;
				state_d = (kind_q == K_CALL || kind_q == K_LONG_JUMP) ? S_EXEC : S_DSREAD;
			end
			S_DSREAD:
			begin
				wdata_d = mod_byte;
				bit_d = tested_bit;
				state_d = (kind_q == K_BIT_TEST) ? S_OPER2 : S_EXEC;
			end
			S_OPER2:
			begin
				addr_d = pm_data_i;
				pc_d = pc_q + PC_STEP;
				state_d = S_EXEC;
			end
			S_EXEC:
			begin
				state_d = S_FETCH;
				case (kind_q)
					K_SHORT_BRANCH:
					begin
						if (short_take)
						begin
							pc_d = pc_q + {{7{short_disp[4]}}, short_disp} + SHORT_BIAS;
						end
					end
					K_BIT_TEST:
					begin
						if (bit_q == op_q[4])
						begin
							pc_d = pc_q + {{4{addr_q[7]}}, addr_q} + LONG_BIAS;
						end
					end
					K_CALL, K_LONG_JUMP:
					begin
						pc_d = {op_q[7:4], addr_q};
						state_d = S_PAD;
					end
					K_SUB_EXIT, K_IRQ_EXIT: pc_d = stack_pop_data_i;
					default: ;
				endcase
			end
			S_PAD: state_d = S_FETCH;
			S_HANDOFF:
			begin
				if (other_done_i)
				begin
					state_d = S_FETCH;
				end
			end
			default: state_d = S_FETCH;
		endcase
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= S_FETCH;
			kind_q <= K_NOP;
			pc_q <= PC_RESET;
			op_q <= 8'h00;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			bit_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			kind_q <= kind_d;
			pc_q <= pc_d;
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			bit_q <= bit_d;
		end
	end

	// ==========================================================
	// Outputs
	assign pm_addr_o = pc_q;
	assign pm_rd_o = (state_q == S_FETCH) || (state_q == S_OPER1) || (state_q == S_OPER2);
	assign ds_addr_o = addr_q;
	assign ds_rd_o = (state_q == S_DSREAD);
	assign ds_wdata_o = wdata_q;
	assign ds_wr_o = (state_q == S_EXEC) && (kind_q == K_BIT_OP);
	assign c_wr_o = (state_q == S_OPER2);
	assign c_val_o = bit_q;
	assign flag_restore_o = (state_q == S_EXEC) && (kind_q == K_IRQ_EXIT);
	assign stack_push_o = (state_q == S_EXEC) && (kind_q == K_CALL);
	assign stack_push_data_o = pc_q;
	assign stack_pop_o = (state_q == S_EXEC) && (kind_q == K_SUB_EXIT || kind_q == K_IRQ_EXIT);
	assign stop_req_o = (state_q == S_EXEC) && (kind_q == K_STOP) && !watchdog_sel_i;
	assign wait_req_o = (state_q == S_EXEC)
		&& (kind_q == K_WAIT || (kind_q == K_STOP && watchdog_sel_i));
	assign illegal_o = (state_q == S_EXEC) && (kind_q == K_ILLEGAL);
	assign other_op_o = (state_q == S_HANDOFF);
	assign other_class_o = other_of(op_q);
	assign other_opcode_o = op_q;

endmodule : bbd_decoder

// ---- test/bbd_decoder_assertions.sv ----
// Port checker for the branch, bit and control decoder
`timescale 1ns/1ns
module bbd_decoder_chk
	import bbd_pkg::*;
(
	input wire logic core_clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic pm_rd_o, // Fetch
	input wire logic [11:0] pm_addr_o, // Pc
	input wire logic ds_rd_o, // Read
	input wire logic [7:0] ds_rdata_i, // Read byte
	input wire logic ds_wr_o, // Write
	input wire logic [7:0] ds_wdata_o, // Write byte
	input wire logic c_wr_o, // Carry load
	input wire logic flag_restore_o, // Restore
	input wire logic stack_push_o, // Push
	input wire logic stack_pop_o, // Pop
	input wire logic [11:0] stack_pop_data_i, // Stack top
	input wire logic watchdog_sel_i, // Watchdog
	input wire logic stop_req_o, // Stop
	input wire logic wait_req_o, // Wait
	input wire logic illegal_o, // Illegal
	input wire logic other_op_o, // Hand-off
	input wire logic other_done_i // Hand-off done
);
	// ==========================================================
	// Sequences
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_rmw;
		ds_rd_o ##1 ds_wr_o;
	endsequence
	sequence s_btest;
		ds_rd_o ##1 (c_wr_o && pm_rd_o);
	endsequence
	// ==========================================================
	// Properties
	AST_DS_RD: assert property (ds_rd_o |-> s_rmw or s_btest)
		else $error("read not followed by write or carry load");
	AST_WR_DATA: assert property (ds_wr_o |-> $countones(ds_wdata_o ^ $past(ds_rdata_i)) <= 1)
		else $error("bit op changed more than one bit");
	AST_WR_FLAGS: assert property (ds_wr_o |-> !c_wr_o && !flag_restore_o ##1 pm_rd_o)
		else $error("bit op touched flags or overran");
	AST_BT_DONE: assert property (c_wr_o |=> !pm_rd_o ##1 pm_rd_o)
		else $error("bit test length wrong");
	AST_POP_PC: assert property (stack_pop_o |=> pm_addr_o == $past(stack_pop_data_i) && pm_rd_o)
		else $error("pop not loaded into pc");
	AST_RESTORE: assert property (flag_restore_o |-> stack_pop_o)
		else $error("restore without pop");
	AST_PUSH: assert property (stack_push_o |-> !stack_pop_o && !c_wr_o && !flag_restore_o ##2 pm_rd_o)
		else $error("call sequence wrong");
	AST_STOP_WD: assert property (stop_req_o |-> !watchdog_sel_i && !wait_req_o)
		else $error("stop with watchdog selected");
	AST_CTRL: assert property ((wait_req_o || illegal_o) |=> pm_rd_o)
		else $error("control op not two cycles");
	AST_OTHER: assert property (other_op_o && other_done_i |=> !other_op_o && pm_rd_o)
		else $error("hand-off not ended");
endmodule : bbd_decoder_chk

bind bbd_decoder bbd_decoder_chk u_chk (.core_clk_i, .rst_i, .pm_rd_o, .pm_addr_o, .ds_rd_o,
	.ds_rdata_i, .ds_wr_o, .ds_wdata_o, .c_wr_o, .flag_restore_o, .stack_push_o, .stack_pop_o,
	.stack_pop_data_i, .watchdog_sel_i, .stop_req_o, .wait_req_o, .illegal_o, .other_op_o,
	.other_done_i);

// ---- test/bbd_pmem.sv ----
// Program memory model for the decoder
`timescale 1ns/1ns
module bbd_pmem (
	input wire logic core_clk_i, // Clock
	input wire logic [11:0] pm_addr_i, // Address
	input wire logic pm_rd_i, // Read strobe
	output logic [7:0] pm_data_o // Byte out
);
	logic [7:0] mem [4096];
	logic [7:0] last_q = 8'h00;
	// Released bus shows a changing pattern
	assign pm_data_o = pm_rd_i ? mem[pm_addr_i] : ~last_q;
	always_ff @(posedge core_clk_i)
	begin
		last_q <= pm_data_o;
	end
endmodule : bbd_pmem

// ---- test/bbd_decoder_tb_top.sv ----
// Self-checking bench for the decoder
`timescale 1ns/1ns
module bbd_decoder_tb_top;
	import bbd_pkg::*;
	typedef struct {logic [7:0] op, b3; logic [2:0] f; logic [7:0] ds; int n;
		logic [11:0] pc; logic [7:0] m, ax;} bbd_row_t;
	logic core_clk_i = 1'b0, rst_i = 1'b1, z_flag_i = 1'b0, c_flag_i = 1'b0;
	logic watchdog_sel_i = 1'b0, pm_rd_o, ds_rd_o, ds_wr_o, c_wr_o, c_val_o, flag_restore_o;
	logic stack_push_o, stack_pop_o, stop_req_o, wait_req_o, illegal_o, other_op_o;
	logic [11:0] pm_addr_o, stack_push_data_o;
	logic [7:0] pm_data_i, ds_addr_o, ds_rdata_i, ds_wdata_o, ds_q = 8'h00, m_q, ax_q, adr_q;
	logic [3:0] other_class_o;
	logic [7:0] other_opcode_o;
	logic other_done_i = 1'b1;
	int failures = 0, tests_run = 0;
	bbd_row_t rows [29] = '{
		'{8'h00,8'h00,3'h0,8'h00,2,12'h002,8'h00,8'h00}, '{8'h00,8'h00,3'h4,8'h00,2,12'h001,8'h00,8'h00},
		'{8'h78,8'h00,3'h0,8'h00,2,12'h011,8'h00,8'h00}, '{8'h80,8'h00,3'h0,8'h00,2,12'hff2,8'h00,8'h00},
		'{8'h72,8'h00,3'h0,8'h00,2,12'h010,8'h00,8'h00}, '{8'h04,8'h00,3'h4,8'h00,2,12'h002,8'h00,8'h00},
		'{8'h06,8'h00,3'h2,8'h00,2,12'h002,8'h00,8'h00}, '{8'h03,8'h7f,3'h0,8'h00,5,12'h084,8'h01,8'h00},
		'{8'h03,8'h7f,3'h0,8'h01,5,12'h003,8'h01,8'h01}, '{8'h13,8'h80,3'h0,8'h01,5,12'hf85,8'h01,8'h01},
		'{8'he3,8'h04,3'h0,8'h7f,5,12'h009,8'h01,8'h00}, '{8'h51,8'h00,3'h0,8'h00,4,12'h534,8'h20,8'h02},
		'{8'h59,8'h00,3'h0,8'h00,4,12'h534,8'h00,8'h00}, '{8'h9b,8'h00,3'h0,8'h00,4,12'h002,8'h00,8'h02},
		'{8'h2b,8'h00,3'h0,8'hff,4,12'h002,8'h00,8'hef}, '{8'had,8'h00,3'h0,8'h00,2,12'h001,8'h00,8'h00},
		'{8'hcd,8'h00,3'h0,8'h00,2,12'h123,8'h10,8'h00}, '{8'h4d,8'h00,3'h0,8'h00,2,12'h123,8'h18,8'h00},
		'{8'h6d,8'h00,3'h0,8'h00,2,12'h001,8'h04,8'h00}, '{8'h6d,8'h00,3'h1,8'h00,2,12'h001,8'h02,8'h00},
		'{8'hed,8'h00,3'h0,8'h00,2,12'h001,8'h02,8'h00}, '{8'h25,8'h00,3'h0,8'h00,2,12'h001,8'h80,8'h00},
		'{8'h15,8'h00,3'h0,8'h00,2,12'h001,8'h40,{4'h0,O_INC_X}},
		'{8'h57,8'h00,3'h0,8'h00,2,12'h001,8'h40,{4'h0,O_SUM_IMMEDIATE}},
		'{8'h87,8'h00,3'h0,8'h00,2,12'h001,8'h40,{4'h0,O_STORE_IND}},
		'{8'h0e,8'h00,3'h2,8'h00,2,12'h003,8'h00,8'h00},
		'{8'hac,8'h00,3'h4,8'h00,2,12'hff7,8'h00,8'h00},
		'{8'h1a,8'h00,3'h2,8'h00,2,12'h001,8'h00,8'h00},
		'{8'h77,8'h00,3'h0,8'h00,2,12'h001,8'h80,8'h00}};

	// Bit ops only ever target plain data bytes, never port registers
	assign ds_rdata_i = ds_rd_o ? ds_q : ~ds_q;
	bbd_pmem u_pm (.core_clk_i(core_clk_i), .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o),
		.pm_data_o(pm_data_i));
	bbd_decoder DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .pm_addr_o(pm_addr_o),
		.pm_rd_o(pm_rd_o), .pm_data_i(pm_data_i), .ds_addr_o(ds_addr_o), .ds_rd_o(ds_rd_o),
		.ds_rdata_i(ds_rdata_i), .ds_wr_o(ds_wr_o), .ds_wdata_o(ds_wdata_o), .z_flag_i(z_flag_i),
		.c_flag_i(c_flag_i), .c_wr_o(c_wr_o), .c_val_o(c_val_o), .flag_restore_o(flag_restore_o),
		.stack_push_o(stack_push_o), .stack_push_data_o(stack_push_data_o),
		.stack_pop_o(stack_pop_o), .stack_pop_data_i(12'h123), .watchdog_sel_i(watchdog_sel_i),
		.stop_req_o(stop_req_o), .wait_req_o(wait_req_o), .illegal_o(illegal_o),
		.other_op_o(other_op_o), .other_class_o(other_class_o),
		.other_opcode_o(other_opcode_o), .other_done_i(other_done_i));

	// ==========================================================
	// Event capture, cleared by each reset
	always @(posedge core_clk_i or posedge rst_i)
		if (rst_i)
		begin
			m_q <= 8'h00;
			ax_q <= 8'h00;
			adr_q <= 8'h00;
		end
		else
		begin
			m_q <= m_q | {illegal_o, other_op_o, stack_push_o, stack_pop_o, flag_restore_o,
				stop_req_o, wait_req_o, c_wr_o};
			if (ds_wr_o) ax_q <= ds_wdata_o;
			if (c_wr_o) ax_q <= {7'h00, c_val_o};
			if (other_op_o) ax_q <= {4'h0, other_class_o};
			if (stack_push_o) ax_q <= stack_push_data_o[7:0];
			if (ds_rd_o) adr_q <= ds_addr_o;
		end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		tests_run++;
		if (s !== e)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic end_sim;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	task automatic run(input bbd_row_t r);
		@(posedge core_clk_i);
		#1 rst_i = 1'b1;
		{z_flag_i, c_flag_i, watchdog_sel_i} = r.f;
		ds_q = r.ds;
		u_pm.mem[0] = r.op;
		u_pm.mem[2] = r.b3;
		@(posedge core_clk_i);
		#1 rst_i = 1'b0;
		repeat (r.n) @(posedge core_clk_i);
		#1 chk(pm_addr_o, r.pc);
		chk(m_q, r.m);
		chk(ax_q, r.ax);
		if (r.op[2:0] == 3'b011) chk(adr_q, 8'h34);
		if (r.m[6]) chk(other_opcode_o, r.op);
	endtask : run

	// ==========================================================
	// Clock, watchdog and main sequence
	initial
	begin
		forever #2 core_clk_i = ~core_clk_i;
	end

	initial
	begin
		#20000 failures++;
		end_sim();
	end

	initial
	begin
		for (int i = 0; i < 4096; i++) u_pm.mem[i] = 8'had;
		u_pm.mem[1] = 8'h34;
		repeat (16) @(posedge core_clk_i);
		#1 chk(pm_addr_o, 12'h000);
		chk(pm_rd_o, 1'b1);
		foreach (rows[i])
		begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		// Set then bit test back to back
		u_pm.mem[3] = 8'h34;
		u_pm.mem[4] = 8'h05;
		run('{8'h9b,8'h93,3'h0,8'h02,9,12'h00c,8'h01,8'h01});
		$display("back to back done");
		// Hand-off held until the other unit finishes
		other_done_i = 1'b0;
		run('{8'h15,8'h00,3'h0,8'h00,4,12'h001,8'h40,8'h00});
		chk(other_op_o, 1'b1);
		other_done_i = 1'b1;
		@(posedge core_clk_i);
		#1 chk(other_op_o, 1'b0);
		chk(pm_rd_o, 1'b1);
		$display("hand-off hold done");
		#1 rst_i = 1'b1;
		#1 chk(pm_addr_o, 12'h000);
		chk(pm_rd_o, 1'b1);
		$display("reset done");
		end_sim();
	end
endmodule : bbd_decoder_tb_top
